// file: rtl/gated_sixteen_bit_timer.sv
// Gated 16-bit timer with prescaler, external clock, crystal enable and overflow interrupt
//
// Summary of operation
// R01: The count clock is divided by 1, 2, 4 or 8 as the prescale select field chooses.
// R02: Any write to the count high or low byte clears the prescale counter.
// R03: The prescale counter is never visible to or writable by software.
// R04: Setting the oscillator enable bit starts the crystal driver, which keeps running in sleep.
// R05: With the count preset to FC00h and the flag clear, the flag sets after 1024 count clocks.
// R06: With the unsynchronised bit set the external clock edge is used without phase retiming.
// R07: External unsynchronised counting continues in sleep and its overflow can wake the core.
// R08: Switching between synchronised and unsynchronised modes may drop or add one increment.
// R09: A read of either count byte always returns a valid byte.
// R10: Software reading the two bytes separately must allow for an overflow between reads.
// R11: Software should stop the counter before writing the count bytes.
// R12: Gated counting is enabled by the gate enable bit with polarity from a separate bit.
// R13: While the gate is active the count rises on each rising edge of the count clock.
// R14: Without gating in effect the count rises on every count clock edge; the code counts only rising edges, after the prescaler.
// R15: In gated mode the count advances only when the gate level equals the polarity bit.
// R16: The gate comes from one of several selectable sources.
// R17: The count rolls from all ones to zero, setting the sticky overflow flag.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module gated_sixteen_bit_timer
	import gated_timer_pkg::*;
#(
	parameter int CLK_FREQ_HZ = 125_000_000
) (
	// Clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  srst_in,
	// Register port
	input  wire logic [ADDR_W-1:0]     addr_in,
	input  wire logic [DATA_W-1:0]     wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output logic      [DATA_W-1:0]     rdata_out,
	// External count clock and gate sources (asynchronous pins)
	input  wire logic                  count_clock_source_in,
	input  wire logic [GATE_SRC_N-1:0] gate_input_in,
	// Processor sleep state
	input  wire logic                  sleep_in,
	// Crystal driver control and wake
	output logic                       crystal_drive_en_out,
	output logic                       wake_out,
	// Interrupt
	output logic                       irq_out
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [1:0]            ext_clk_meta;
	logic [GATE_SRC_N-1:0] gate_meta;
	logic [GATE_SRC_N-1:0] gate_sync;
	logic                  ext_clk_sync;
	logic                  ext_clk_prev;
	logic                  ext_clk_raw_prev;

	// Two stages before any logic reads the pins
	always_ff @(posedge clk_sys_in) begin
		ext_clk_meta <= {ext_clk_meta[0], count_clock_source_in};
		gate_meta    <= gate_input_in;
		gate_sync    <= gate_meta;
	end

	assign ext_clk_sync = ext_clk_meta[1];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	timer_ctrl_t       ctrl;
	gate_ctrl_t        gate_ctrl;
	logic              low_freq_osc_enable;
	logic [15:0]       count;
	logic [PRESCALE_CNT_W-1:0] prescale_cnt;
	logic              overflow_flag;
	logic              irq_mask;

	// Write decode
	wire wr_ctrl  = wr_in && (addr_in == ADDR_TIMER_CONTROL);
	wire wr_gate  = wr_in && (addr_in == ADDR_GATE_CONTROL);
	wire wr_low   = wr_in && (addr_in == ADDR_COUNT_LOW);
	wire wr_high  = wr_in && (addr_in == ADDR_COUNT_HIGH);
	wire wr_osc   = wr_in && (addr_in == ADDR_OSC_ENABLE);
	wire wr_mask  = wr_in && (addr_in == ADDR_IRQ_MASK);
	wire rd_stat  = rd_in && (addr_in == ADDR_IRQ_STATUS);
	wire wr_count = wr_low || wr_high;

	// ------------------------------------------------------------
	// Count clock edge selection
	// ------------------------------------------------------------
	// Unsynchronised mode skips the extra retiming flop, so its edge is one
	// cycle earlier; a mode change may therefore drop or add one edge.
	wire ext_edge_sync   = ext_clk_raw_prev && !ext_clk_prev;
	wire ext_edge_unsync = ext_clk_sync && !ext_clk_raw_prev;
	wire sys_tick        = 1'b1;
	// R06 direct edge use
	// R08 edge slip on switch
	wire count_edge = !ctrl.ext_clk ? sys_tick :
		(ctrl.unsync ? ext_edge_unsync : ext_edge_sync);

	// Internal clock stops in sleep; unsynchronised external keeps going
	// R07 counting in sleep
	wire clk_alive = !sleep_in || (ctrl.ext_clk && ctrl.unsync);

	// Retiming chain for the synchronised path; both taps always run so a
	// mode switch sees settled history rather than a stale flop
	always_ff @(posedge clk_sys_in) begin
		ext_clk_raw_prev <= ext_clk_sync;
		ext_clk_prev     <= ext_clk_raw_prev;
	end

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	function automatic logic [PRESCALE_CNT_W-1:0] prescale_limit(input logic [PRESCALE_W-1:0] sel);
		prescale_limit = PRESCALE_CNT_W'((1 << sel) - 1);
	endfunction

	wire src_edge   = count_edge && clk_alive && ctrl.timer_on;
	// R01 divide by 1 2 4 8
	// At or above the limit counts as done, so a count left over from a larger
	// ratio wraps on the next edge instead of running up to the counter width
	wire prescale_done = (prescale_cnt >= prescale_limit(ctrl.prescale_select));

	// R02 clear on count write
	// R03 hidden prescale state
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || wr_count) begin
			prescale_cnt <= '0;
		end else if (src_edge) begin
			prescale_cnt <= prescale_done ? '0 : prescale_cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Gate
	// ------------------------------------------------------------
	// R16 gate source select
	wire gate_level = gate_sync[gate_ctrl.gate_source];
	// R12 gate enable and polarity
	// R15 level equals polarity
	wire gate_open  = !gate_ctrl.gate_enable || (gate_level == gate_ctrl.gate_polarity);
	// R13 count on rising edge
	// R14 free running otherwise
	wire inc        = src_edge && prescale_done && gate_open;

	// ------------------------------------------------------------
	// Counter and overflow
	// ------------------------------------------------------------
	// R17 rollover sets flag
	wire rollover = inc && (count == COUNT_ONES);
	// R05 preset start-up check
	wire [15:0] next_count = wr_low  ? {count[15:8], wdata_in} :
	                         wr_high ? {wdata_in, count[7:0]} :
	                         inc     ? 16'(count + 1'b1) : count;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			count <= COUNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	// Set wins over the clear-on-read
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			overflow_flag <= 1'b0;
		end else if (rollover) begin
			overflow_flag <= 1'b1;
		end else if (rd_stat) begin
			overflow_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ctrl                <= '0;
			gate_ctrl           <= '0;
			low_freq_osc_enable <= 1'b0;
			irq_mask            <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= {wdata_in[TC_PRESCALE_LSB +: PRESCALE_W], wdata_in[TC_EXT_CLK_BIT],
					wdata_in[TC_UNSYNC_BIT], wdata_in[TC_ON_BIT]};
			end
			if (wr_gate) begin
				gate_ctrl <= {wdata_in[GC_ENABLE_BIT], wdata_in[GC_POLARITY_BIT],
					wdata_in[GC_SOURCE_LSB +: GATE_SRC_W]};
			end
			if (wr_osc) begin
				low_freq_osc_enable <= wdata_in[OSC_ENABLE_BIT];
			end
			if (wr_mask) begin
				irq_mask <= wdata_in[IRQ_OVERFLOW_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux, one cycle latency
	// ------------------------------------------------------------
	logic [DATA_W-1:0] rd_mux;
	// R09 count bytes always valid
	always_comb begin
		rd_mux = BYTE_ZERO;
		unique case (addr_in)
			ADDR_TIMER_CONTROL: begin
				rd_mux[TC_PRESCALE_LSB +: PRESCALE_W] = ctrl.prescale_select;
				rd_mux[TC_EXT_CLK_BIT]                = ctrl.ext_clk;
				rd_mux[TC_UNSYNC_BIT]                 = ctrl.unsync;
				rd_mux[TC_ON_BIT]                     = ctrl.timer_on;
			end
			ADDR_GATE_CONTROL: begin
				rd_mux[GC_ENABLE_BIT]                 = gate_ctrl.gate_enable;
				rd_mux[GC_POLARITY_BIT]               = gate_ctrl.gate_polarity;
				rd_mux[GC_SOURCE_LSB +: GATE_SRC_W]   = gate_ctrl.gate_source;
			end
			ADDR_COUNT_LOW:   rd_mux = count[7:0];
			ADDR_COUNT_HIGH:  rd_mux = count[15:8];
			ADDR_OSC_ENABLE:  rd_mux[OSC_ENABLE_BIT]   = low_freq_osc_enable;
			ADDR_IRQ_STATUS:  rd_mux[IRQ_OVERFLOW_BIT] = overflow_flag;
			ADDR_IRQ_MASK:    rd_mux[IRQ_OVERFLOW_BIT] = irq_mask;
			default:          rd_mux = BYTE_ZERO;
		endcase
	end

	// Pending unmasked overflow; a rollover in the reading cycle keeps it up
	logic next_irq;
	assign next_irq = (overflow_flag || rollover) && irq_mask && !(rd_stat && !rollover);

	// Outputs straight from flops
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rdata_out            <= BYTE_ZERO;
			irq_out              <= 1'b0;
			crystal_drive_en_out <= 1'b0;
			wake_out             <= 1'b0;
		end else begin
			rdata_out            <= rd_in ? rd_mux : BYTE_ZERO;
			irq_out              <= next_irq;
			// R04 crystal runs in sleep too
			crystal_drive_en_out <= low_freq_osc_enable;
			wake_out             <= next_irq && sleep_in;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_count_write_prescale: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R02
		wr_count |=> (prescale_cnt == '0))
		else $error("prescale not cleared by count write");
	chk_prescale_bound: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R01
		(src_edge && !wr_ctrl) |=> (prescale_cnt <= prescale_limit(ctrl.prescale_select)))
		else $error("prescale count above limit");
	chk_rollover_flag: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R17
		rollover |=> overflow_flag && (count == COUNT_ZERO || $past(wr_count)))
		else $error("rollover without flag");
	chk_gate_hold: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R15
		(gate_ctrl.gate_enable && gate_level != gate_ctrl.gate_polarity && !wr_count) |=> $stable(count))
		else $error("count moved with gate closed");
	chk_free_count: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R14
		(!gate_ctrl.gate_enable && !ctrl.ext_clk && ctrl.timer_on && !sleep_in && !wr_count
		 && ctrl.prescale_select == '0) |=> (count == 16'($past(count) + 1'b1)))
		else $error("free running count stalled");
	chk_gate_count: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R13
		(inc && !wr_count) |=> (count == 16'($past(count) + 1'b1)))
		else $error("gated increment lost");
	chk_crystal_enable: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R04
		(wr_osc && wdata_in[OSC_ENABLE_BIT]) |=> ##1 crystal_drive_en_out)
		else $error("crystal not enabled");
	chk_sleep_hold: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R07
		(sleep_in && !ctrl.ext_clk && !wr_count) |=> $stable(count))
		else $error("internal clock counted in sleep");
	chk_irq_level: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R17
		(overflow_flag && irq_mask && !rd_stat) |=> irq_out)
		else $error("interrupt not raised");

	// Flag is sticky until a status read, and the interrupt drops with it
	chk_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R17
		(overflow_flag && !rd_stat) |=> overflow_flag)
		else $error("overflow flag lost without a read");
	chk_flag_clear: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R17
		(rd_stat && !rollover) |=> !overflow_flag)
		else $error("status read left flag set");
	chk_irq_quiet: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R17
		(!overflow_flag && !rollover) |=> !irq_out)
		else $error("interrupt without pending overflow");

	// Wake only asks for the core while it sleeps
	chk_wake_sleep: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R07
		(sleep_in && overflow_flag && irq_mask && !rd_stat) |=> wake_out)
		else $error("sleeping core not woken");
	chk_wake_awake: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R07
		!sleep_in |=> !wake_out)
		else $error("wake raised while awake");

	// Crystal driver follows its enable bit whatever the sleep state
	chk_crystal_follow: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R04
		crystal_drive_en_out == $past(low_freq_osc_enable))
		else $error("crystal driver does not follow enable");

	// Edge paths: unsynchronised counts at once, synchronised one cycle later
	chk_unsync_count: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R06
		(ctrl.ext_clk && ctrl.unsync && ctrl.timer_on && ext_clk_sync && !ext_clk_raw_prev
		 && ctrl.prescale_select == '0 && !gate_ctrl.gate_enable && !wr_count)
		|=> (count == 16'($past(count) + 1'b1)))
		else $error("unsynchronised edge not counted");
	chk_sync_lag: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R08
		(ctrl.ext_clk && !ctrl.unsync && ext_clk_sync && !ext_clk_raw_prev)
		|-> !count_edge ##1 (count_edge || $past(wr_ctrl)))
		else $error("synchronised edge not one cycle late");

	// Gate level comes from the selected source only
	chk_gate_source: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R16
		(gate_ctrl.gate_enable && inc) |-> (gate_sync[gate_ctrl.gate_source] == gate_ctrl.gate_polarity))
		else $error("gate source not honoured");

	// Read data stand one cycle after the strobe and are zero otherwise
	chk_read_low: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R09
		(rd_in && addr_in == ADDR_COUNT_LOW) |=> (rdata_out == 8'($past(count))))
		else $error("count low byte read wrong");
	chk_read_high: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R09
		(rd_in && addr_in == ADDR_COUNT_HIGH) |=> (rdata_out == 8'($past(count) >> DATA_W)))
		else $error("count high byte read wrong");
	chk_read_idle: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R09
		!rd_in |=> (rdata_out == BYTE_ZERO))
		else $error("read data outside read cycle");

	cov_rollover:   cover property (@(posedge clk_sys_in) disable iff (srst_in) rollover);
	cov_gate_block: cover property (@(posedge clk_sys_in) disable iff (srst_in) src_edge && !gate_open);
	cov_unsync_inc: cover property (@(posedge clk_sys_in) disable iff (srst_in) inc && ctrl.unsync);
	cov_sleep_wake: cover property (@(posedge clk_sys_in) disable iff (srst_in) wake_out);
	cov_sync_inc:   cover property (@(posedge clk_sys_in) disable iff (srst_in) inc && ctrl.ext_clk && !ctrl.unsync);

endmodule

`default_nettype wire

// file: rtl/gated_timer_pkg.sv
// Package: register map, fields and timing constants of the gated 16-bit timer
package gated_timer_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte-wide registers, index addressing)
	// ------------------------------------------------------------
	localparam int          ADDR_W              = 4;
	localparam int          DATA_W              = 8;
	localparam logic [3:0]  ADDR_TIMER_CONTROL  = 4'h0;
	localparam logic [3:0]  ADDR_GATE_CONTROL   = 4'h1;
	localparam logic [3:0]  ADDR_COUNT_LOW      = 4'h2;
	localparam logic [3:0]  ADDR_COUNT_HIGH     = 4'h3;
	localparam logic [3:0]  ADDR_OSC_ENABLE     = 4'h4;
	localparam logic [3:0]  ADDR_IRQ_STATUS     = 4'h5;
	localparam logic [3:0]  ADDR_IRQ_MASK       = 4'h6;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          TC_ON_BIT           = 0;
	localparam int          TC_UNSYNC_BIT       = 2;
	localparam int          TC_EXT_CLK_BIT      = 3;
	localparam int          TC_PRESCALE_LSB     = 4;
	localparam int          GC_ENABLE_BIT       = 7;
	localparam int          GC_POLARITY_BIT     = 6;
	localparam int          GC_SOURCE_LSB       = 0;
	localparam int          OSC_ENABLE_BIT      = 3;
	localparam int          IRQ_OVERFLOW_BIT    = 0;

	// ------------------------------------------------------------
	// Widths, reset values and fixed figures
	// ------------------------------------------------------------
	localparam int          PRESCALE_W          = 2;
	localparam int          PRESCALE_CNT_W      = 3;
	localparam int          GATE_SRC_W          = 2;
	localparam int          GATE_SRC_N          = 4;
	localparam logic [7:0]  BYTE_ZERO           = 8'h00;
	localparam logic [15:0] COUNT_ZERO          = 16'h0000;
	localparam logic [15:0] COUNT_ONES          = 16'hFFFF;
	localparam logic [15:0] STARTUP_PRESET      = 16'hFC00;
	localparam int          STARTUP_CYCLES      = 1024;

	// Control register bundle
	typedef struct packed {
		logic [PRESCALE_W-1:0] prescale_select;
		logic                  ext_clk;
		logic                  unsync;
		logic                  timer_on;
	} timer_ctrl_t;

	typedef struct packed {
		logic                  gate_enable;
		logic                  gate_polarity;
		logic [GATE_SRC_W-1:0] gate_source;
	} gate_ctrl_t;

endpackage

// file: tb/ext_source_model.sv
// Far-side model: external count clock pin and the four gate source pins
`timescale 1ns/1ps
`default_nettype none

module ext_source_model (
	// Clock
	input  wire logic       clk_sys_in,
	// Pins towards the timer
	output logic            count_clock_source_out,
	output logic [3:0]      gate_input_out
);
	// Clock pin rests low between bursts, gates start low
	initial begin
		count_clock_source_out = 1'b0;
		gate_input_out         = 4'h0;
	end

	// ------------------------------------------------------------
	// Count clock bursts
	// ------------------------------------------------------------
	// n rising edges, high and low for h cycles each; h >= 2 is slow enough to sync
	task automatic pulse(input int n, input int h);
		repeat (n) begin
			@(posedge clk_sys_in);
			count_clock_source_out <= 1'b1;
			repeat (h) @(posedge clk_sys_in);
			count_clock_source_out <= 1'b0;
			repeat (h - 1) @(posedge clk_sys_in);
		end
	endtask

	// ------------------------------------------------------------
	// Gate sources
	// ------------------------------------------------------------
	// Unselected lines take the opposite level, so a wrong source pick shows
	task automatic set_gate(input int src, input logic lvl);
		logic [3:0] lines;
		@(posedge clk_sys_in);
		lines          = {4{~lvl}};
		lines[src]     = lvl;
		gate_input_out <= lines;
	endtask
endmodule

`default_nettype wire

// file: tb/gated_sixteen_bit_timer_tb.sv
// Self-checking bench of the gated 16-bit timer
`timescale 1ns/1ps
`default_nettype none

module gated_sixteen_bit_timer_tb;
	import gated_timer_pkg::*;

	logic                  clk_sys_in;
	logic                  srst_in;
	logic [ADDR_W-1:0]     addr_in;
	logic [DATA_W-1:0]     wdata_in;
	logic                  wr_in;
	logic                  rd_in;
	logic                  sleep_in;
	logic [DATA_W-1:0]     rdata_out;
	logic                  crystal_drive_en_out;
	logic                  wake_out;
	logic                  irq_out;
	logic                  count_clock_source;
	logic [GATE_SRC_N-1:0] gate_input;
	int                    n_fail;
	int                    comparisons;
	logic [15:0]           seen;

	gated_sixteen_bit_timer gated_sixteen_bit_timer_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.count_clock_source_in(count_clock_source), .gate_input_in(gate_input), .sleep_in(sleep_in),
		.crystal_drive_en_out(crystal_drive_en_out), .wake_out(wake_out), .irq_out(irq_out));

	ext_source_model ext_source_model_i (.clk_sys_in(clk_sys_in),
		.count_clock_source_out(count_clock_source), .gate_input_out(gate_input));

	// 125 MHz clock
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	// ------------------------------------------------------------
	// Bus cycles and comparison
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in    <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in   <= 1'b0;
		#1 d = rdata_out;
	endtask

	// Low byte first; only used while no edges arrive, so no rollover between halves
	// reads at rest
	task automatic rd16(output logic [15:0] v);
		rd(ADDR_COUNT_LOW, v[7:0]);
		rd(ADDR_COUNT_HIGH, v[15:8]);
	endtask

	// Timer stopped before the count bytes are written, avoiding write contention
	// stop first
	task automatic set_count(input logic [15:0] v);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		wr(ADDR_COUNT_LOW, v[7:0]);
		wr(ADDR_COUNT_HIGH, v[15:8]);
	endtask

	// Run on the external pin with n edges, then let the synchroniser drain
	task automatic run(input logic [7:0] ctl, input int n);
		wr(ADDR_TIMER_CONTROL, ctl);
		ext_source_model_i.pulse(n, 2);
		repeat (6) @(posedge clk_sys_in);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values;
		rd16(seen);
		check(seen, COUNT_ZERO);
		rd(4'hF, seen[7:0]);
		check(seen[7:0], BYTE_ZERO);
		@(posedge clk_sys_in);
		#1 check(rdata_out, BYTE_ZERO);
	endtask

	task automatic t_prescale;
		for (int s = 0; s < 4; s++) begin
			set_count(16'h00F0);
			run(8'h09 | 8'(s << TC_PRESCALE_LSB), 16);
			rd16(seen);
			check(seen, 16'h00F0 + 16'(16 >> s));
		end
	endtask

	task automatic t_prescale_clear;
		set_count(COUNT_ZERO);
		run(8'h29, 3);
		set_count(COUNT_ZERO);
		run(8'h29, 7);
		rd16(seen);
		check(seen, 16'h0001);
	endtask

	task automatic t_gate;
		for (int p = 0; p < 2; p++) begin
			for (int l = 0; l < 2; l++) begin
				wr(ADDR_GATE_CONTROL, 8'h80 | 8'(p << GC_POLARITY_BIT) | 8'(p * 2 + l));
				ext_source_model_i.set_gate(p * 2 + l, 1'(l));
				set_count(COUNT_ZERO);
				run(8'h09, 5);
				rd16(seen);
				check(seen, (p == l) ? 16'h0005 : COUNT_ZERO);
			end
		end
		wr(ADDR_GATE_CONTROL, 8'h40);
		set_count(COUNT_ZERO);
		run(8'h09, 5);
		rd16(seen);
		check(seen, 16'h0005);
	endtask

	// Internal source counts once per system cycle while the timer is on
	task automatic t_internal;
		set_count(COUNT_ZERO);
		wr(ADDR_TIMER_CONTROL, 8'h01);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		rd16(seen);
		check(seen, 16'h0002);
	endtask

	task automatic t_overflow;
		wr(ADDR_IRQ_MASK, 8'h01);
		set_count(STARTUP_PRESET);
		run(8'h09, STARTUP_CYCLES - 1);
		check(irq_out, 1'b0);
		ext_source_model_i.pulse(1, 2);
		repeat (6) @(posedge clk_sys_in);
		check(irq_out, 1'b1);
		rd16(seen);
		check(seen, COUNT_ZERO);
		rd(ADDR_IRQ_STATUS, seen[7:0]);
		check(seen[7:0], 8'h01);
		repeat (2) @(posedge clk_sys_in);
		check(irq_out, 1'b0);
	endtask

	task automatic t_sleep;
		set_count(COUNT_ZERO);
		sleep_in <= 1'b1;
		run(8'h09, 2);
		rd16(seen);
		check(seen, COUNT_ZERO);
		set_count(COUNT_ONES);
		run(8'h0D, 1);
		check(wake_out, 1'b1);
		check(irq_out, 1'b1);
		sleep_in <= 1'b0;
		rd16(seen);
		check(seen, COUNT_ZERO);
		rd(ADDR_IRQ_STATUS, seen[7:0]);
		wr(ADDR_OSC_ENABLE, 8'h08);
		repeat (2) @(posedge clk_sys_in);
		#1 check(crystal_drive_en_out, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic stop_test;
		if (n_fail == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Whole sequence needs about 4800 cycles
	initial begin
		#(8 * 40000);
		n_fail++;
		stop_test();
	end

	initial begin
		n_fail = 0;
		comparisons = 0;
		srst_in = 1'b1;
		addr_in = 4'h0;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		sleep_in = 1'b0;
		repeat (20) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		t_reset_values();
		t_prescale();
		t_prescale_clear();
		t_gate();
		t_internal();
		t_overflow();
		t_sleep();
		stop_test();
	end
endmodule

`default_nettype wire
